// ### sipp_pkg.sv
package sipp_pkg;
	// timing
	localparam int MCLK_PERIOD_NS = 40;
	localparam int NS_PER_US = 1000;
	localparam int FLASH_PAGE_WAIT_TIME_US = 4500;
	localparam int EEPROM_BYTE_WAIT_TIME_US = 9000;
	localparam int CHIP_ERASE_WAIT_TIME_US = 9000;
	localparam int FUSE_WRITE_WAIT_TIME_US = 4500;
	localparam int FLASH_PAGE_WAIT_CYCLES =
		(FLASH_PAGE_WAIT_TIME_US * NS_PER_US + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int EEPROM_BYTE_WAIT_CYCLES =
		(EEPROM_BYTE_WAIT_TIME_US * NS_PER_US + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int CHIP_ERASE_WAIT_CYCLES =
		(CHIP_ERASE_WAIT_TIME_US * NS_PER_US + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int FUSE_WRITE_WAIT_CYCLES =
		(FUSE_WRITE_WAIT_TIME_US * NS_PER_US + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int WAIT_W = 20;
	// memory geometry
	localparam int FLASH_WORDS = 1024;
	localparam int PAGE_WORDS = 16;
	localparam int PAGE_ADDR_W = 6;
	localparam int IN_PAGE_W = 4;
	localparam int EE_BYTES = 128;
	localparam int EE_ADDR_W = 7;
	localparam int LOCK_W = 2;
	localparam int FUSE_HI_W = 5;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	// command framing
	localparam int CMD_BITS = 32;
	localparam int CNT_W = 5;
	localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
	localparam logic [CNT_W-1:0] CNT_BYTE3_DONE = 5'h17;
	localparam logic [CNT_W-1:0] CNT_BYTE2_DONE = 5'h0F;
	localparam logic [CNT_W-1:0] CNT_LAST = 5'h1F;
	localparam logic [CNT_W-1:0] CNT_STEP = 5'h01;
	localparam int H_BIT = 27;
	// opcodes
	localparam logic [7:0] OP_PROG_EN = 8'hAC;
	localparam logic [7:0] OP_PE_KEY = 8'h53;
	localparam logic [7:0] OP_CLASS_MASK = 8'hE0;
	localparam logic [7:0] OP_ERASE_CLASS = 8'h80;
	localparam logic [7:0] OP_LOCK_CLASS = 8'hE0;
	localparam logic [7:0] OP_FUSE_LO = 8'hA0;
	localparam logic [7:0] OP_FUSE_HI = 8'hA8;
	localparam logic [7:0] OP_H_MASK = 8'hF7;
	localparam logic [7:0] OP_RD_PROG = 8'h20;
	localparam logic [7:0] OP_LOAD_PAGE = 8'h40;
	localparam logic [7:0] OP_WR_PAGE = 8'h4C;
	localparam logic [7:0] OP_RD_EE = 8'hA0;
	localparam logic [7:0] OP_WR_EE = 8'hC0;
	localparam logic [7:0] OP_RD_LOCK = 8'h58;
	localparam logic [7:0] OP_FUSE_HI_SEL = 8'h08;
	localparam logic [7:0] OP_RD_FUSE = 8'h50;
	localparam logic [7:0] OP_RD_SIG = 8'h30;
	localparam logic [7:0] OP_RD_CAL = 8'h38;
	// identity bytes: arbitrary values
	localparam logic [7:0] SIG_BYTE0 = 8'h5A;
	localparam logic [7:0] SIG_BYTE1 = 8'h11;
	localparam logic [7:0] SIG_BYTE2 = 8'h22;
	localparam logic [7:0] CAL_BYTE = 8'h80;

	typedef enum logic [3:0] {
		CMD_NONE, CMD_PROG_EN, CMD_ERASE, CMD_WR_LOCK, CMD_WR_FUSE_LO, CMD_WR_FUSE_HI,
		CMD_RD_PROG, CMD_LOAD_PAGE, CMD_WR_PAGE, CMD_RD_EE, CMD_WR_EE, CMD_RD_LOCK,
		CMD_RD_FUSE_LO, CMD_RD_FUSE_HI, CMD_RD_SIG, CMD_RD_CAL
	} sipp_cmd_type;

	typedef enum logic [1:0] {
		WAIT_FLASH, WAIT_EEPROM, WAIT_ERASE, WAIT_FUSE
	} sipp_wait_type;

	// first two command bytes to command
	function automatic sipp_cmd_type sipp_decode(input logic [7:0] b1, input logic [7:0] b2);
		sipp_cmd_type c;
		c = CMD_NONE;
		if (b1 == OP_PROG_EN)
		begin
			if (b2 == OP_PE_KEY)
				c = CMD_PROG_EN;
			else if ((b2 & OP_CLASS_MASK) == OP_ERASE_CLASS)
				c = CMD_ERASE;
			else if ((b2 & OP_CLASS_MASK) == OP_LOCK_CLASS)
				c = CMD_WR_LOCK;
			else if (b2 == OP_FUSE_LO)
				c = CMD_WR_FUSE_LO;
			else if (b2 == OP_FUSE_HI)
				c = CMD_WR_FUSE_HI;
		end
		else if ((b1 & OP_H_MASK) == OP_RD_PROG)
			c = CMD_RD_PROG;
		else if ((b1 & OP_H_MASK) == OP_LOAD_PAGE)
			c = CMD_LOAD_PAGE;
		else if (b1 == OP_WR_PAGE)
			c = CMD_WR_PAGE;
		else if (b1 == OP_RD_EE)
			c = CMD_RD_EE;
		else if (b1 == OP_WR_EE)
			c = CMD_WR_EE;
		else if (b1 == OP_RD_LOCK && b2 == OP_FUSE_HI_SEL)
			c = CMD_RD_FUSE_HI;
		else if (b1 == OP_RD_LOCK && b2 == ZERO_BYTE)
			c = CMD_RD_LOCK;
		else if (b1 == OP_RD_FUSE && b2 == ZERO_BYTE)
			c = CMD_RD_FUSE_LO;
		else if (b1 == OP_RD_SIG)
			c = CMD_RD_SIG;
		else if (b1 == OP_RD_CAL)
			c = CMD_RD_CAL;
		return c;
	endfunction
endpackage

// ### sipp_sync.sv
`timescale 1ns/100ps
module sipp_sync
	import sipp_pkg::*;
(
	// clock and clear
	input wire logic clk,
	input wire logic clear,
	// level in and out
	input wire logic d,
	output logic q
);
	typedef struct packed {
		logic s1;
		logic s2;
	} sipp_sync_type;

	sipp_sync_type st;
	sipp_sync_type next_st;

	always_comb
	begin
		next_st.s1 = d;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge clk or posedge clear)
	begin
		if (clear)
			st <= '0;
		else
			st <= next_st;
	end

	assign q = st.s2;
endmodule

// ### sipp_timer.sv
`timescale 1ns/100ps
module sipp_timer
	import sipp_pkg::*;
#(
	parameter int FLASH_CYCLES = FLASH_PAGE_WAIT_CYCLES,
	parameter int EEPROM_CYCLES = EEPROM_BYTE_WAIT_CYCLES,
	parameter int ERASE_CYCLES = CHIP_ERASE_WAIT_CYCLES,
	parameter int FUSE_CYCLES = FUSE_WRITE_WAIT_CYCLES
)
(
	// clock, reset, enable
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	// request
	input wire logic start,
	input wire sipp_wait_type kind,
	// status
	output logic busy
);
	typedef struct packed {
		logic busy;
		logic [WAIT_W-1:0] cnt;
	} sipp_timer_type;

	sipp_timer_type st;
	sipp_timer_type next_st;

	always_comb
	begin
		next_st = st;
		if (start && !st.busy)
		begin
			next_st.busy = 1'b1;
			case (kind)
				WAIT_FLASH: next_st.cnt = WAIT_W'(FLASH_CYCLES - 1);
				WAIT_EEPROM: next_st.cnt = WAIT_W'(EEPROM_CYCLES - 1);
				WAIT_ERASE: next_st.cnt = WAIT_W'(ERASE_CYCLES - 1);
				default: next_st.cnt = WAIT_W'(FUSE_CYCLES - 1);
			endcase
		end
		else if (st.busy)
		begin
			if (st.cnt == '0)
				next_st.busy = 1'b0;
			else
				next_st.cnt = st.cnt - WAIT_W'(1);
		end
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			st <= '0;
		else if (ce)
			st <= next_st;
	end

	assign busy = st.busy;

	AST_BUSY_START: assert property (@(posedge mclk) disable iff (reset)
		(ce && start && !busy) |=> busy)
		else $error("self-timed wait did not start");
	AST_BUSY_END: assert property (@(posedge mclk) disable iff (reset)
		(ce && busy && st.cnt == '0) |=> !busy)
		else $error("self-timed wait did not end on zero count");
endmodule

// ### sipp_top.sv
`timescale 1ns/100ps
// Functional notes
// - EEPROM byte write erases the location itself; no chip erase needed first.
// - chip erase sets all flash and EEPROM to ones; AC then 100x xxxx.
// - data-in is sampled on every rising serial clock edge.
// - data-out changes on every falling serial clock edge.
// - second byte of a command echoes during byte three; unsynchronised commands do nothing.
// - write-page commits the buffer to the page named by six high bits.
// - reads of a page or byte being programmed return ones until done.
// - programming-enable is AC 53 xx xx, accepted only while reset low.
// - read program memory 0010 H000, address in bytes two and three.
// - load page 0100 H000 nibble address and data; write page 4C.
// - EEPROM read A0, write C0, 7-bit address in byte three.
// - lock write AC 111x xxxx xx 1111 11ii; lock read 58 00.
// - fuse writes AC A0 and AC A8; reads 50 00 and 58 08.
// - programming mode only while reset pin low; release resumes normal operation.
// - after reset falls, program and erase refused until programming-enable.
module sipp_top
	import sipp_pkg::*;
#(
	parameter int FLASH_CYCLES = FLASH_PAGE_WAIT_CYCLES,
	parameter int EEPROM_CYCLES = EEPROM_BYTE_WAIT_CYCLES,
	parameter int ERASE_CYCLES = CHIP_ERASE_WAIT_CYCLES,
	parameter int FUSE_CYCLES = FUSE_WRITE_WAIT_CYCLES
)
(
	// system clock, reset, enable
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	// programming pins
	input wire logic prog_reset_n,
	input wire logic sck,
	input wire logic mosi,
	output logic miso,
	// status
	output logic prog_active
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic [CMD_BITS-2:0] sh;
		logic [7:0] out_byte;
		logic en;
		logic pend;
		logic wr_tog;
		sipp_wait_type wr_kind;
		logic [PAGE_ADDR_W-1:0] wr_page;
		logic [EE_ADDR_W-1:0] wr_ee;
	} sipp_link_type;

	typedef struct packed {
		logic pin_s1;
		logic pin_s2;
		logic tog_s1;
		logic tog_s2;
		logic tog_s3;
		logic done_tog;
		logic link_rst;
		logic active;
	} sipp_core_type;

	localparam sipp_core_type CORE_RESET = '{
		pin_s1: 1'b1, pin_s2: 1'b1, tog_s1: 1'b0, tog_s2: 1'b0, tog_s3: 1'b0,
		link_rst: 1'b1, active: 1'b0, done_tog: 1'b0};

	sipp_link_type lk;
	sipp_link_type next_lk;
	sipp_core_type cs;
	sipp_core_type next_cs;

	logic [15:0] flash_mem [FLASH_WORDS];
	logic [7:0] ee_mem [EE_BYTES];
	logic [15:0] page_buf [PAGE_WORDS];
	logic [LOCK_W-1:0] lock_bits;
	logic [7:0] fuse_lo;
	logic [FUSE_HI_W-1:0] fuse_hi;

	logic [CMD_BITS-1:0] full;
	logic last;
	logic do_write;
	sipp_cmd_type cmd_now;
	sipp_cmd_type cmd_hdr;
	logic [7:0] rd_data;
	logic [15:0] rd_word;
	logic busy_s;
	logic timer_busy;
	logic timer_start;

	// mclk domain: pin sync, write toggle sync, link reset
	always_comb
	begin
		next_cs.pin_s1 = prog_reset_n;
		next_cs.pin_s2 = cs.pin_s1;
		next_cs.tog_s1 = lk.wr_tog;
		next_cs.tog_s2 = cs.tog_s1;
		next_cs.tog_s3 = cs.tog_s2;
		next_cs.link_rst = cs.pin_s2;
		next_cs.active = !cs.pin_s2;
		// write toggle handed back once its wait is over, so no sck edge is needed meanwhile
		next_cs.done_tog = cs.done_tog;
		if (!(timer_busy || timer_start))
			next_cs.done_tog = cs.tog_s3;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			cs <= CORE_RESET;
		else if (ce)
			cs <= next_cs;
	end

	assign timer_start = (cs.tog_s2 ^ cs.tog_s3) && !cs.link_rst;
	assign prog_active = cs.active;

	sipp_timer #(
		.FLASH_CYCLES(FLASH_CYCLES),
		.EEPROM_CYCLES(EEPROM_CYCLES),
		.ERASE_CYCLES(ERASE_CYCLES),
		.FUSE_CYCLES(FUSE_CYCLES)
	) u_timer (
		.mclk(mclk),
		.reset(reset),
		.ce(ce),
		.start(timer_start),
		.kind(lk.wr_kind),
		.busy(timer_busy)
	);

	sipp_sync u_busy_sync (
		.clk(sck),
		.clear(cs.link_rst),
		.d(cs.done_tog),
		.q(busy_s)
	);

	// link domain: command decode
	assign full = {lk.sh, mosi};
	assign last = lk.cnt == CNT_LAST;
	assign cmd_now = sipp_decode(full[31:24], full[23:16]);
	assign cmd_hdr = sipp_decode(full[23:16], full[15:8]);
	assign do_write = last && lk.en && !lk.pend;
	assign rd_word = flash_mem[full[9:0]];

	// read data for byte four
	always_comb
	begin
		rd_data = ZERO_BYTE;
		case (cmd_hdr)
			CMD_RD_PROG:
			begin
				if (lk.pend && lk.wr_kind == WAIT_FLASH && full[9:4] == lk.wr_page)
					rd_data = ERASED_BYTE;
				else if (full[19])
					rd_data = rd_word[15:8];
				else
					rd_data = rd_word[7:0];
			end
			CMD_RD_EE:
			begin
				if (lk.pend && lk.wr_kind == WAIT_EEPROM && full[6:0] == lk.wr_ee)
					rd_data = ERASED_BYTE;
				else
					rd_data = ee_mem[full[6:0]];
			end
			CMD_RD_LOCK:
			begin
				rd_data = ERASED_BYTE;
				rd_data[LOCK_W-1:0] = lock_bits;
			end
			CMD_RD_FUSE_LO: rd_data = fuse_lo;
			CMD_RD_FUSE_HI: rd_data[FUSE_HI_W-1:0] = fuse_hi;
			CMD_RD_SIG:
			begin
				case (full[1:0])
					2'h0: rd_data = SIG_BYTE0;
					2'h1: rd_data = SIG_BYTE1;
					2'h2: rd_data = SIG_BYTE2;
					default: rd_data = ERASED_BYTE;
				endcase
			end
			CMD_RD_CAL: rd_data = CAL_BYTE;
			default: rd_data = ZERO_BYTE;
		endcase
		if (!lk.en)
			rd_data = ZERO_BYTE;
	end

	// link domain: shifting, echo, enable, write issue
	always_comb
	begin
		next_lk = lk;
		next_lk.cnt = lk.cnt + CNT_STEP;
		next_lk.sh = full[CMD_BITS-2:0];
		if (lk.cnt[2:0] == BYTE_LAST_BIT)
			next_lk.out_byte = full[7:0];
		if (lk.cnt == CNT_BYTE3_DONE)
			next_lk.out_byte = rd_data;
		if (last)
			next_lk.out_byte = ZERO_BYTE;
		if (lk.pend && busy_s == lk.wr_tog)
			next_lk.pend = 1'b0;
		if (last && cmd_now == CMD_PROG_EN)
			next_lk.en = 1'b1;
		if (do_write)
		begin
			case (cmd_now)
				CMD_ERASE, CMD_WR_LOCK, CMD_WR_FUSE_LO, CMD_WR_FUSE_HI, CMD_WR_PAGE, CMD_WR_EE:
				begin
					next_lk.pend = 1'b1;
					next_lk.wr_tog = !lk.wr_tog;
				end
				default: next_lk.pend = lk.pend;
			endcase
			case (cmd_now)
				CMD_ERASE: next_lk.wr_kind = WAIT_ERASE;
				CMD_WR_PAGE:
				begin
					next_lk.wr_kind = WAIT_FLASH;
					next_lk.wr_page = {full[17:16], full[15:12]};
				end
				CMD_WR_EE:
				begin
					next_lk.wr_kind = WAIT_EEPROM;
					next_lk.wr_ee = full[14:8];
				end
				CMD_WR_LOCK, CMD_WR_FUSE_LO, CMD_WR_FUSE_HI: next_lk.wr_kind = WAIT_FUSE;
				default: next_lk.wr_kind = lk.wr_kind;
			endcase
		end
	end

	always_ff @(posedge sck or posedge cs.link_rst)
	begin
		if (cs.link_rst)
			lk <= '0;
		else
			lk <= next_lk;
	end

	// data out on the falling edge
	always_ff @(negedge sck or posedge cs.link_rst)
	begin
		if (cs.link_rst)
			miso <= 1'b0;
		else
			miso <= lk.out_byte[BYTE_LAST_BIT - lk.cnt[2:0]];
	end

	// nonvolatile arrays, page buffer, fuse and lock bits
	always_ff @(posedge sck)
	begin
		if (do_write)
		begin
			case (cmd_now)
				CMD_LOAD_PAGE:
				begin
					if (full[H_BIT])
						page_buf[full[11:8]][15:8] <= full[7:0];
					else
						page_buf[full[11:8]][7:0] <= full[7:0];
				end
				CMD_WR_PAGE:
				begin
					for (int i = 0; i < PAGE_WORDS; i++)
					begin
						flash_mem[{full[17:16], full[15:12], IN_PAGE_W'(i)}] <=
							flash_mem[{full[17:16], full[15:12], IN_PAGE_W'(i)}] & page_buf[i];
						page_buf[i] <= ERASED_WORD;
					end
				end
				CMD_WR_EE: ee_mem[full[14:8]] <= full[7:0];
				CMD_ERASE:
				begin
					for (int i = 0; i < FLASH_WORDS; i++)
						flash_mem[i] <= ERASED_WORD;
					for (int i = 0; i < EE_BYTES; i++)
						ee_mem[i] <= ERASED_BYTE;
					lock_bits <= '1;
				end
				CMD_WR_LOCK: lock_bits <= lock_bits & full[LOCK_W-1:0];
				CMD_WR_FUSE_LO: fuse_lo <= full[7:0];
				CMD_WR_FUSE_HI: fuse_hi <= full[FUSE_HI_W-1:0];
				default: fuse_lo <= fuse_lo;
			endcase
		end
	end

	AST_DIN_SAMPLE: assert property (@(posedge sck) disable iff (cs.link_rst)
		1'b1 |=> lk.sh[0] == $past(mosi))
		else $error("data-in not sampled on rising edge");
	AST_DOUT_BIT: assert property (@(posedge sck) disable iff (cs.link_rst)
		1'b1 |-> miso == lk.out_byte[BYTE_LAST_BIT - lk.cnt[2:0]])
		else $error("data-out bit does not match falling-edge shift");
	AST_ECHO: assert property (@(posedge sck) disable iff (cs.link_rst)
		(lk.cnt == CNT_BYTE2_DONE) |=> lk.out_byte == $past(full[7:0]))
		else $error("second byte not echoed during byte three");
	AST_PE_ACCEPT: assert property (@(posedge sck) disable iff (cs.link_rst)
		(last && cmd_now == CMD_PROG_EN) |=> lk.en)
		else $error("programming-enable not accepted");
	AST_LOCKED_OUT: assert property (@(posedge sck) disable iff (cs.link_rst)
		!lk.en |=> $stable(lk.wr_tog) && !lk.pend)
		else $error("write issued before programming-enable");
	AST_BUSY_BLOCKS: assert property (@(posedge sck) disable iff (cs.link_rst)
		lk.pend |=> $stable(lk.wr_tog) && $stable(lk.wr_page) && $stable(lk.wr_ee))
		else $error("write issued while busy");
	AST_EE_POLL_FF: assert property (@(posedge sck) disable iff (cs.link_rst)
		(lk.cnt == CNT_BYTE3_DONE && lk.en && cmd_hdr == CMD_RD_EE && lk.pend
		&& lk.wr_kind == WAIT_EEPROM && full[6:0] == lk.wr_ee) |=> lk.out_byte == ERASED_BYTE)
		else $error("EEPROM poll during write not all ones");
	AST_EE_WRITE: assert property (@(posedge sck) disable iff (cs.link_rst)
		(do_write && cmd_now == CMD_WR_EE) |=> ee_mem[$past(full[14:8])] == $past(full[7:0]))
		else $error("EEPROM byte not written");
	AST_ERASE_ALL: assert property (@(posedge sck) disable iff (cs.link_rst)
		(do_write && cmd_now == CMD_ERASE) |=> ee_mem[0] == ERASED_BYTE
		&& flash_mem[FLASH_WORDS-1] == ERASED_WORD)
		else $error("chip erase left a location unerased");
endmodule

// ### sipp_prog_model.sv
`timescale 1ns/100ps
module sipp_prog_model
(
	// system clock used to time the reset pin
	input wire logic mclk,
	// programming pins
	output logic prog_reset_n,
	output logic sck,
	output logic mosi,
	input wire logic miso
);
	// half period of the serial clock, raised by the bench for a slow programmer
	int half_ns = 40;

	initial
	begin
		prog_reset_n = 1'b1;
		sck = 1'b0;
		mosi = 1'b0;
	end

	// clock held low, pin pulsed high, then held low for the session
	task automatic enter(input int settle);
		@(posedge mclk);
		#2 sck = 1'b0;
		prog_reset_n = 1'b1;
		repeat (3) @(posedge mclk);
		#2 prog_reset_n = 1'b0;
		repeat (settle) @(posedge mclk);
	endtask

	task automatic leave();
		@(posedge mclk);
		#2 prog_reset_n = 1'b1;
		repeat (8) @(posedge mclk);
	endtask

	// whole command, always four bytes, msb first; clock idles low between frames
	task automatic xfer(input logic [31:0] c, output logic [31:0] got);
		got = 32'h0000_0000;
		// off the system clock's phase, and the released data line lasts a while
		#7;
		for (int i = 31; i >= 0; i--)
		begin
			mosi = c[i];
			#(half_ns) sck = 1'b1;
			got[i] = miso;
			#(half_ns) sck = 1'b0;
		end
		// released data line shows no stale value
		mosi = ~mosi;
	endtask
endmodule

// ### tb.sv
`timescale 1ns/100ps
`define CHK(g, e) \
	begin \
		n_checks++; \
		if ((g) !== (e)) \
		begin \
			err_total++; \
			$display("BAD %0t got %h expected %h", $time, (g), (e)); \
		end \
	end
module tb
	import sipp_pkg::*;
;
	logic mclk;
	logic reset;
	logic ce;
	logic prog_reset_n;
	logic sck;
	logic mosi;
	logic miso;
	logic prog_active;
	int err_total = 0;
	int n_checks = 0;

	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	sipp_top #(
		.FLASH_CYCLES(150),
		.EEPROM_CYCLES(300),
		.ERASE_CYCLES(300),
		.FUSE_CYCLES(150)
	) i_dut (
		.mclk(mclk),
		.reset(reset),
		.ce(ce),
		.prog_reset_n(prog_reset_n),
		.sck(sck),
		.mosi(mosi),
		.miso(miso),
		.prog_active(prog_active)
	);

	sipp_prog_model i_prog (
		.mclk(mclk),
		.prog_reset_n(prog_reset_n),
		.sck(sck),
		.mosi(mosi),
		.miso(miso)
	);

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	function automatic logic [31:0] fl_rd(input logic [9:0] a, input logic h);
		return {4'h2, h, 3'h0, 6'h00, a, 8'h00};
	endfunction

	function automatic logic [31:0] ee_rd(input logic [6:0] a);
		return {8'hA0, 8'h00, 1'b0, a, 8'h00};
	endfunction

	function automatic logic [7:0] sig_exp(input logic [1:0] b);
		case (b)
			2'h0: return SIG_BYTE0;
			2'h1: return SIG_BYTE1;
			2'h2: return SIG_BYTE2;
			default: return 8'hFF;
		endcase
	endfunction

	task automatic cmd(input logic [31:0] c, output logic [7:0] r);
		logic [31:0] g;
		i_prog.xfer(c, g);
		r = g[7:0];
	endtask

	task automatic idle(input int n);
		logic [7:0] r;
		repeat (n) cmd(32'h3000_0000, r);
	endtask

	// polls a read until it returns the written value, then one more to clear the wait
	task automatic poll(input logic [31:0] c, input logic [7:0] e);
		logic [7:0] r;
		r = 8'hFF;
		for (int k = 0; k < 40 && r !== e; k++)
			cmd(c, r);
		`CHK(r, e)
		if (r !== e)
			give_verdict();
		idle(1);
	endtask

	task automatic enable();
		logic [31:0] g;
		i_prog.xfer(32'hAC53_0000, g);
		`CHK(g[23:16], 8'hAC)
		`CHK(g[15:8], 8'h53)
	endtask

	// data out may only move while the serial clock is low
	always @(miso)
		if (reset === 1'b0 && prog_reset_n === 1'b0)
			`CHK(sck, 1'b0)

	initial
	begin
		#2_000_000;
		err_total++;
		$display("BAD %0t run did not finish", $time);
		give_verdict();
	end

	initial
	begin
		logic [7:0] r;
		logic [7:0] d1;
		logic [7:0] d2;
		logic [6:0] ea;
		logic [6:0] eb;
		logic [9:0] fa;
		logic [5:0] pg;
		logic [31:0] g;
		logic [15:0] words [16];
		reset = 1'b1;
		ce = 1'b1;
		void'($urandom(32'hbc98d887));
		repeat (3) @(posedge mclk);
		#2 reset = 1'b0;
		i_prog.enter(8);
		`CHK(prog_active, 1'b1)
		i_prog.xfer(32'hAC52_0000, g);
		cmd(32'h3000_0000, r);
		`CHK(r, 8'h00)
		enable();
		for (int b = 0; b < 4; b++)
		begin
			cmd({8'h30, 8'h00, 6'h00, b[1:0], 8'h00}, r);
			`CHK(r, sig_exp(b[1:0]))
		end
		cmd(32'h3800_0000, r);
		`CHK(r, CAL_BYTE)
		$display("ident test done");
		cmd(32'hAC80_0000 | ($urandom & 32'h001F_FFFF), r);
		idle(8);
		for (int k = 0; k < 6; k++)
		begin
			fa = 10'($urandom);
			ea = 7'($urandom);
			cmd(fl_rd(fa, k[0]), r);
			`CHK(r, 8'hFF)
			cmd(ee_rd(ea), r);
			`CHK(r, 8'hFF)
		end
		cmd(32'h5800_0000, r);
		`CHK(r, 8'hFF)
		$display("erase test done");
		ea = 7'($urandom);
		eb = ea + 7'h01;
		d1 = 8'($urandom_range(254, 1));
		cmd({8'hC0, 8'h00, 1'b0, ea, d1}, r);
		cmd({8'hC0, 8'h00, 1'b0, eb, 8'h00}, r);
		cmd(ee_rd(ea), r);
		`CHK(r, 8'hFF)
		poll(ee_rd(ea), d1);
		cmd(ee_rd(eb), r);
		`CHK(r, 8'hFF)
		d2 = ~d1;
		cmd({8'hC0, 8'h00, 1'b0, ea, d2}, r);
		poll(ee_rd(ea), d2);
		$display("eeprom test done");
		pg = 6'($urandom);
		foreach (words[w])
			words[w] = 16'($urandom);
		words[0][0] = 1'b0;
		for (int w = 0; w < 16; w++)
		begin
			cmd({8'h40, 8'h00, 4'h0, w[3:0], words[w][7:0]}, r);
			cmd({8'h48, 8'h00, 4'h0, w[3:0], words[w][15:8]}, r);
		end
		cmd({8'h4C, 6'h00, pg, 4'h0, 8'h00}, r);
		cmd(fl_rd({pg, 4'h0}, 1'b0), r);
		`CHK(r, 8'hFF)
		poll(fl_rd({pg, 4'h0}, 1'b0), words[0][7:0]);
		for (int w = 0; w < 16; w++)
		begin
			cmd(fl_rd({pg, w[3:0]}, 1'b0), r);
			`CHK(r, words[w][7:0])
			cmd(fl_rd({pg, w[3:0]}, 1'b1), r);
			`CHK(r, words[w][15:8])
		end
		cmd(fl_rd({pg + 6'h01, 4'h3}, 1'b1), r);
		`CHK(r, 8'hFF)
		$display("flash test done");
		i_prog.half_ns = 200;
		cmd(ee_rd(ea), r);
		`CHK(r, d2)
		i_prog.half_ns = 40;
		$display("slow clock test done");
		d1 = 8'($urandom);
		cmd({16'hACA0, 8'h00, d1}, r);
		// unpolled wait with the link clock stopped; the next write must still land
		repeat (200) @(posedge mclk);
		cmd(32'h5000_0000, r);
		`CHK(r, d1)
		cmd({16'hACA8, 8'h00, ~d1}, r);
		idle(4);
		cmd(32'h5808_0000, r);
		`CHK(r, {3'h0, ~d1[4:0]})
		$display("fuse test done");
		i_prog.leave();
		`CHK(prog_active, 1'b0)
		i_prog.enter(8);
		cmd({8'hC0, 8'h00, 1'b0, eb, 8'h11}, r);
		enable();
		cmd(ee_rd(eb), r);
		`CHK(r, 8'hFF)
		$display("session test done");
		cmd({8'hAC, 8'hE0, 8'h00, 6'h3F, d1[1:0]}, r);
		idle(4);
		cmd(32'h5800_0000, r);
		`CHK(r, {6'h3F, d1[1:0]})
		$display("lock test done");
		// mid-run reset ends the session; ce low keeps the pin synchroniser frozen
		@(posedge mclk);
		#2 reset = 1'b1;
		ce = 1'b0;
		repeat (3) @(posedge mclk);
		#2 reset = 1'b0;
		repeat (6) @(posedge mclk);
		`CHK(prog_active, 1'b0)
		#2 ce = 1'b1;
		repeat (4) @(posedge mclk);
		`CHK(prog_active, 1'b1)
		cmd(32'h3800_0000, r);
		`CHK(r, 8'h00)
		$display("reset test done");
		give_verdict();
	end
endmodule
